// File: verilog/pdc_pkg.sv
package pdc_pkg;

  // ----------------------------------------------------------------
  // register map: printed offsets are word indices, byte address = 4x
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned REG_W = 16;
  localparam int unsigned CTRL_IDX = 32'h48;
  localparam int unsigned STS_IDX = 32'h4a;
  localparam int unsigned DBG_IDX = 32'h50;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'(CTRL_IDX * 4);
  localparam logic [ADDR_W-1:0] STS_ADDR = ADDR_W'(STS_IDX * 4);
  localparam logic [ADDR_W-1:0] DBG_ADDR = ADDR_W'(DBG_IDX * 4);

  // ----------------------------------------------------------------
  // device_control fields
  // ----------------------------------------------------------------
  localparam int unsigned CTL_ENABLE_LSB = 0;
  localparam int unsigned CTL_RELAXED_BIT = 4;
  localparam int unsigned CTL_MPS_LSB = 5;
  localparam int unsigned MPS_W = 3;
  localparam int unsigned CTL_EXT_TAG_BIT = 8;
  localparam int unsigned CTL_PHANTOM_BIT = 9;
  localparam int unsigned CTL_AUX_PM_BIT = 10;
  localparam int unsigned CTL_NO_SNOOP_BIT = 11;
  localparam int unsigned CTL_MAX_READ_REQUEST_SIZE_LSB = 12;
  localparam logic [REG_W-1:0] CTRL_RW_MASK = 16'h01ef;
  localparam logic [REG_W-1:0] CTRL_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // device_status fields
  // ----------------------------------------------------------------
  localparam int unsigned ERR_N = 4;
  localparam logic [REG_W-1:0] STS_W1C_MASK = 16'h000f;
  localparam logic [ERR_N-1:0] STS_RESET = 4'h0;

  // ----------------------------------------------------------------
  // debug_control fields (sequential tag mode, payload capability view)
  // ----------------------------------------------------------------
  localparam int unsigned DBG_SEQ_TAG_BIT = 0;
  localparam int unsigned DBG_CAP_LSB = 4;
  localparam logic [REG_W-1:0] DBG_RW_MASK = 16'h0001;
  localparam logic [REG_W-1:0] DBG_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // payload and tag encodings
  // ----------------------------------------------------------------
  localparam logic [MPS_W-1:0] MPS_MAX_CODE = 3'h4;
  localparam logic [MPS_W-1:0] MPS_FALLBACK = 3'h0;
  localparam logic [MPS_W-1:0] MAX_PAYLOAD_SUPPORTED_RST = 3'h4;
  localparam int unsigned PAYLOAD_W = 12;
  localparam logic [PAYLOAD_W-1:0] PAYLOAD_BASE_BYTES = 12'h080;
  localparam int unsigned TAG_W = 8;
  localparam logic [TAG_W-1:0] TAG_MAX_SHORT = 8'h1f;
  localparam logic [TAG_W-1:0] TAG_MAX_EXT = 8'hff;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic unsupported;
    logic fatal;
    logic nonfatal;
    logic correctable;
  } pdc_err_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } pdc_apb_req_s;

endpackage

// File: verilog/pdc_w1c_flags.sv
`timescale 1ns/1ps
module pdc_w1c_flags #(
  parameter int unsigned N = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // events and clears
  input wire logic [N-1:0] set_i,
  input wire logic [N-1:0] clr_i,
  // flags
  output logic [N-1:0] flags_o
);

  // ----------------------------------------------------------------
  // one sticky cell per bit; set beats clear so no event is lost
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_flag
    logic flag_reg;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        flag_reg <= 1'b0;
      end else if (set_i[i]) begin
        flag_reg <= 1'b1;
      end else if (clr_i[i]) begin
        flag_reg <= 1'b0;
      end
    end
    assign flags_o[i] = flag_reg;
  end

endmodule

// File: verilog/pdc_apb_slave.sv
`timescale 1ns/1ps
module pdc_apb_slave (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // bus request and answer
  input wire pdc_pkg::pdc_apb_req_s req_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // register read values
  input wire logic [pdc_pkg::REG_W-1:0] ctrl_rd_i,
  input wire logic [pdc_pkg::REG_W-1:0] sts_rd_i,
  input wire logic [pdc_pkg::REG_W-1:0] dbg_rd_i,
  // write strobes and data
  output logic wr_ctrl_o,
  output logic wr_sts_o,
  output logic wr_dbg_o,
  output logic [pdc_pkg::REG_W-1:0] wdata_o
);

  logic hit_ctrl;
  logic hit_sts;
  logic hit_dbg;
  logic hit_any;
  logic commit;
  logic [31:0] rdata_reg;

  // ----------------------------------------------------------------
  // decode; no wait states, so every access phase completes
  // ----------------------------------------------------------------
  assign hit_ctrl = req_i.paddr == pdc_pkg::CTRL_ADDR;
  assign hit_sts = req_i.paddr == pdc_pkg::STS_ADDR;
  assign hit_dbg = req_i.paddr == pdc_pkg::DBG_ADDR;
  assign hit_any = hit_ctrl | hit_sts | hit_dbg;
  assign pready_o = 1'b1;
  assign pslverr_o = req_i.psel & req_i.penable & ~hit_any;
  assign commit = req_i.psel & req_i.penable & req_i.pwrite;
  assign wr_ctrl_o = commit & hit_ctrl;
  assign wr_sts_o = commit & hit_sts;
  assign wr_dbg_o = commit & hit_dbg;
  assign wdata_o = req_i.pwdata[pdc_pkg::REG_W-1:0];

  // read data captured at the end of setup so it comes from a flop
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req_i.psel && !req_i.penable) begin
      unique case (1'b1)
        hit_ctrl: rdata_reg <= {16'h0000, ctrl_rd_i};
        hit_sts: rdata_reg <= {16'h0000, sts_rd_i};
        hit_dbg: rdata_reg <= {16'h0000, dbg_rd_i};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata_o = rdata_reg;

endmodule

// File: verilog/pdc_dev_ctrl_status.sv
//
// Functional notes
// [RULE_01] four reporting enables gate their error class
// [RULE_02] relaxed ordering bit zero, never originated
// [RULE_03] payload field codes 0..4 select 128..2048
// [RULE_04] payload codes 5..7 act as 128 bytes
// [RULE_05] extended tag only widens debug sequential tags
// [RULE_06] phantom function bit reads zero
// [RULE_07] aux power management bit reads zero
// [RULE_08] no snoop never originated, forwarded unchanged
// [RULE_09] read request size zero, forwarded unchanged
// [RULE_10] error flags sticky, set always, write-one clears
// [RULE_11] unsupported request sets status bit three
// [RULE_12] aux power detected reads zero
// [RULE_13] transactions pending reads zero
// [RULE_14] supported payload capability defaults to 2048
// [RULE_15] reserved bits read zero, ignore writes
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module pdc_dev_ctrl_status #(
  parameter logic [2:0] MAX_PAYLOAD_SUPPORTED = pdc_pkg::MAX_PAYLOAD_SUPPORTED_RST
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pdc_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // error detection and reporting
  input wire pdc_pkg::pdc_err_s err_i,
  output pdc_pkg::pdc_err_s err_report_o,
  // payload limits
  output logic [pdc_pkg::MPS_W-1:0] max_payload_code_o,
  output logic [pdc_pkg::PAYLOAD_W-1:0] max_payload_bytes_o,
  output logic [pdc_pkg::MPS_W-1:0] max_payload_supported_o,
  // originated transaction attributes
  output logic relaxed_ordering_attr_o,
  output logic no_snoop_attr_o,
  // forwarded transaction attributes
  input wire logic fwd_no_snoop_i,
  input wire logic [2:0] fwd_read_size_i,
  output logic fwd_no_snoop_o,
  output logic [2:0] fwd_read_size_o,
  // debug tag generator
  input wire logic tag_req_i,
  output logic [pdc_pkg::TAG_W-1:0] tag_o
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (MAX_PAYLOAD_SUPPORTED > pdc_pkg::MPS_MAX_CODE) begin : g_bad_cap
    $error("max payload supported code above the largest legal code");
  end

  pdc_pkg::pdc_apb_req_s apb_req;
  logic wr_ctrl;
  logic wr_sts;
  logic wr_dbg;
  logic [pdc_pkg::REG_W-1:0] wdata;
  logic [pdc_pkg::REG_W-1:0] ctrl_reg;
  logic [pdc_pkg::REG_W-1:0] dbg_reg;
  logic [pdc_pkg::REG_W-1:0] ctrl_rd;
  logic [pdc_pkg::REG_W-1:0] sts_rd;
  logic [pdc_pkg::REG_W-1:0] dbg_rd;
  logic [pdc_pkg::ERR_N-1:0] enables;
  logic [pdc_pkg::ERR_N-1:0] err_vec;
  logic [pdc_pkg::ERR_N-1:0] sts_clr;
  logic [pdc_pkg::ERR_N-1:0] sts_flags;
  logic [pdc_pkg::MPS_W-1:0] mps_field;
  logic [pdc_pkg::MPS_W-1:0] mps_eff;
  logic ext_tag;
  logic seq_tag_debug;
  logic [pdc_pkg::TAG_W-1:0] tag_reg;
  logic [pdc_pkg::TAG_W-1:0] tag_next;
  logic [pdc_pkg::TAG_W-1:0] tag_limit;
  pdc_pkg::pdc_err_s report_reg;
  logic [pdc_pkg::MPS_W-1:0] mps_code_reg;
  logic [pdc_pkg::PAYLOAD_W-1:0] mps_bytes_reg;
  logic fwd_ns_reg;
  logic [2:0] fwd_size_reg;

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  assign apb_req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
                     paddr: paddr_i, pwdata: pwdata_i};

  pdc_apb_slave u_apb (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .req_i(apb_req),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .ctrl_rd_i(ctrl_rd),
    .sts_rd_i(sts_rd),
    .dbg_rd_i(dbg_rd),
    .wr_ctrl_o(wr_ctrl),
    .wr_sts_o(wr_sts),
    .wr_dbg_o(wr_dbg),
    .wdata_o(wdata)
  );

  // ----------------------------------------------------------------
  // device_control: only writable bits are stored, hardwired ones
  // are masked so they can never drift from zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg <= pdc_pkg::CTRL_RESET; // RULE_01
    end else if (wr_ctrl) begin
      ctrl_reg <= wdata & pdc_pkg::CTRL_RW_MASK; // RULE_06 RULE_07 RULE_15
    end
  end
  assign ctrl_rd = ctrl_reg & pdc_pkg::CTRL_RW_MASK; // RULE_02 RULE_08 RULE_09
  assign enables = ctrl_reg[pdc_pkg::CTL_ENABLE_LSB +: pdc_pkg::ERR_N];
  assign mps_field = ctrl_reg[pdc_pkg::CTL_MPS_LSB +: pdc_pkg::MPS_W];
  assign ext_tag = ctrl_reg[pdc_pkg::CTL_EXT_TAG_BIT];

  // debug_control: sequential tag switch plus a view of the capability
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dbg_reg <= pdc_pkg::DBG_RESET;
    end else if (wr_dbg) begin
      dbg_reg <= wdata & pdc_pkg::DBG_RW_MASK;
    end
  end
  assign seq_tag_debug = dbg_reg[pdc_pkg::DBG_SEQ_TAG_BIT];
  assign dbg_rd = (dbg_reg & pdc_pkg::DBG_RW_MASK)
                | (pdc_pkg::REG_W'(MAX_PAYLOAD_SUPPORTED) << pdc_pkg::DBG_CAP_LSB); // RULE_14

  // ----------------------------------------------------------------
  // device_status: flags log every error whatever the enables say
  // ----------------------------------------------------------------
  assign err_vec = err_i; // RULE_10 RULE_11
  assign sts_clr = wr_sts ? wdata[pdc_pkg::ERR_N-1:0] : pdc_pkg::STS_RESET;

  pdc_w1c_flags #(
    .N(pdc_pkg::ERR_N)
  ) u_flags (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .set_i(err_vec),
    .clr_i(sts_clr),
    .flags_o(sts_flags)
  );

  // aux power detected, transactions pending and reserved bits stay zero
  assign sts_rd = pdc_pkg::REG_W'(sts_flags) & pdc_pkg::STS_W1C_MASK; // RULE_12 RULE_13 RULE_15

  // ----------------------------------------------------------------
  // error reporting: each enable gates its own class only
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      report_reg <= '0;
    end else begin
      report_reg <= err_i & enables; // RULE_01
    end
  end
  assign err_report_o = report_reg;

  // ----------------------------------------------------------------
  // payload size: reserved codes fall back to the smallest payload
  // ----------------------------------------------------------------
  always_comb begin
    if (mps_field > pdc_pkg::MPS_MAX_CODE) begin
      mps_eff = pdc_pkg::MPS_FALLBACK; // RULE_04
    end else begin
      mps_eff = mps_field; // RULE_03
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mps_code_reg <= pdc_pkg::MPS_FALLBACK;
      mps_bytes_reg <= pdc_pkg::PAYLOAD_BASE_BYTES;
    end else begin
      mps_code_reg <= mps_eff;
      mps_bytes_reg <= pdc_pkg::PAYLOAD_BASE_BYTES << mps_eff; // RULE_03
    end
  end
  assign max_payload_code_o = mps_code_reg;
  assign max_payload_bytes_o = mps_bytes_reg;
  assign max_payload_supported_o = MAX_PAYLOAD_SUPPORTED; // RULE_14

  // ----------------------------------------------------------------
  // attributes: nothing originated carries relaxed ordering or
  // no snoop; forwarded attributes pass untouched, one flop late
  // ----------------------------------------------------------------
  assign relaxed_ordering_attr_o = 1'b0; // RULE_02
  assign no_snoop_attr_o = 1'b0; // RULE_08

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fwd_ns_reg <= 1'b0;
      fwd_size_reg <= 3'h0;
    end else begin
      fwd_ns_reg <= fwd_no_snoop_i; // RULE_08
      fwd_size_reg <= fwd_read_size_i; // RULE_09
    end
  end
  assign fwd_no_snoop_o = fwd_ns_reg;
  assign fwd_read_size_o = fwd_size_reg;

  // ----------------------------------------------------------------
  // debug tag generator; idle at zero outside sequential tag mode,
  // since normal operation issues no tagged requests of its own
  // ----------------------------------------------------------------
  assign tag_limit = ext_tag ? pdc_pkg::TAG_MAX_EXT : pdc_pkg::TAG_MAX_SHORT; // RULE_05

  always_comb begin
    if (tag_reg >= tag_limit) begin
      tag_next = '0; // a narrowed range also wraps an out-of-range count
    end else begin
      tag_next = tag_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tag_reg <= '0;
    end else if (!seq_tag_debug) begin
      tag_reg <= '0; // RULE_05
    end else if (tag_req_i) begin
      tag_reg <= tag_next; // RULE_05
    end
  end
  assign tag_o = tag_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  logic ctrl_wr_commit;
  assign ctrl_wr_commit = psel_i & penable_i & pwrite_i & (paddr_i == pdc_pkg::CTRL_ADDR);

  a_enable_gate: assert property ( // RULE_01
    err_i.fatal |=> err_report_o.fatal == $past(enables[2]))
    else $error("fatal report does not follow its enable");

  a_enable_block: assert property ( // RULE_01
    (err_i.correctable && !enables[0]) |=> !err_report_o.correctable)
    else $error("correctable report leaked while disabled");

  a_relaxed_zero: assert property ( // RULE_02
    !relaxed_ordering_attr_o && !ctrl_rd[pdc_pkg::CTL_RELAXED_BIT])
    else $error("relaxed ordering seen as set");

  a_mps_write: assert property ( // RULE_03
    (ctrl_wr_commit && pwdata_i[7:5] <= 3'h4) |=> ##1
      max_payload_bytes_o == (12'h080 << $past(pwdata_i[7:5], 2)))
    else $error("payload bytes do not match written code");

  a_mps_reserved: assert property ( // RULE_04
    (ctrl_wr_commit && pwdata_i[7:5] > 3'h4) |=> ##1
      (max_payload_bytes_o == 12'h080 && max_payload_code_o == 3'h0))
    else $error("reserved payload code not treated as 128 bytes");

  a_tag_short: assert property ( // RULE_05
    (seq_tag_debug && !ext_tag && tag_req_i) |=> tag_o <= 8'h1f)
    else $error("short tag range exceeded");

  a_tag_idle: assert property ( // RULE_05
    !seq_tag_debug |=> tag_o == 8'h00)
    else $error("tag moved outside debug mode");

  a_phantom_zero: assert property ( // RULE_06
    ctrl_wr_commit |=> !ctrl_rd[pdc_pkg::CTL_PHANTOM_BIT])
    else $error("phantom function bit took a write");

  a_aux_pm_zero: assert property ( // RULE_07
    ctrl_wr_commit |=> !ctrl_rd[pdc_pkg::CTL_AUX_PM_BIT])
    else $error("aux power management bit took a write");

  // the copy taken at the release edge is still the reset value, so skip it
  a_no_snoop_fwd: assert property ( // RULE_08
    arst_n_i |=> (fwd_no_snoop_o == $past(fwd_no_snoop_i) && !no_snoop_attr_o
      && !ctrl_rd[pdc_pkg::CTL_NO_SNOOP_BIT]))
    else $error("no snoop altered or originated");

  a_read_size_fwd: assert property ( // RULE_09
    arst_n_i |=> (fwd_read_size_o == $past(fwd_read_size_i)
      && ctrl_rd[pdc_pkg::CTL_MAX_READ_REQUEST_SIZE_LSB +: 3] == 3'h0))
    else $error("read request size altered or nonzero");

  a_flag_sticky: assert property ( // RULE_10
    (sts_flags[2] && !(wr_sts && wdata[2])) |=> sts_flags[2])
    else $error("fatal flag lost without a clear");

  a_flag_set_wins: assert property ( // RULE_10
    (err_i.nonfatal && wr_sts && wdata[1]) |=> sts_flags[1] [*2])
    else $error("clear beat a same-cycle error");

  a_ur_detect: assert property ( // RULE_11
    err_i.unsupported |=> sts_rd[3])
    else $error("unsupported request not logged");

  a_sts_hardwired: assert property ( // RULE_12
    sts_rd[15:4] == 12'h000)
    else $error("hardwired status bits not zero");

  a_pending_zero: assert property ( // RULE_13
    ##1 (sts_rd[5] == 1'b0 && $stable(sts_rd[5])))
    else $error("transactions pending flag moved");

  a_cap_value: assert property ( // RULE_14
    max_payload_supported_o == MAX_PAYLOAD_SUPPORTED
      && dbg_rd[pdc_pkg::DBG_CAP_LSB +: 3] == MAX_PAYLOAD_SUPPORTED)
    else $error("payload capability mismatch");

  a_reserved_ctrl: assert property ( // RULE_15
    ctrl_wr_commit && pwdata_i[15] |=> !ctrl_rd[15] && !prdata_o[15] [*1])
    else $error("reserved control bit stored a write");

  a_flag_clear: assert property ( // RULE_10
    (sts_flags[0] && wr_sts && wdata[0] && !err_i.correctable) |=> !sts_flags[0])
    else $error("correctable flag not cleared by a one");

  a_ctrl_readback: assert property ( // RULE_15
    ctrl_wr_commit |=> ctrl_rd == ($past(pwdata_i[15:0]) & 16'h01ef))
    else $error("control register kept the wrong bits");

  a_report_quiet: assert property ( // RULE_01
    err_i == 4'h0 |=> err_report_o == 4'h0)
    else $error("report pulse without an error");

  a_tag_ext_wrap: assert property ( // RULE_05
    (seq_tag_debug && ext_tag && tag_req_i && tag_o == 8'hff) |=> tag_o == 8'h00)
    else $error("extended tag range did not wrap after 255");

  c_error_logged: cover property (err_i.fatal && enables[2] ##1 err_report_o.fatal);
  c_flag_cleared: cover property (sts_flags[0] ##1 wr_sts && wdata[0] ##1 !sts_flags[0]);
  c_tag_wrap: cover property (seq_tag_debug && tag_req_i && tag_o == 8'h1f ##1 tag_o == 8'h00);
  c_mps_reserved: cover property (mps_field == 3'h7);

endmodule

// File: verification/tb_pdc_dev_ctrl_status.sv
`timescale 1ns/1ps
module tb_pdc_dev_ctrl_status;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [pdc_pkg::ADDR_W-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  pdc_pkg::pdc_err_s err_i = '0;
  pdc_pkg::pdc_err_s err_report_o;
  logic [pdc_pkg::MPS_W-1:0] max_payload_code_o;
  logic [pdc_pkg::PAYLOAD_W-1:0] max_payload_bytes_o;
  logic [pdc_pkg::MPS_W-1:0] max_payload_supported_o;
  logic relaxed_ordering_attr_o;
  logic no_snoop_attr_o;
  logic fwd_no_snoop_i = 1'b0;
  logic [2:0] fwd_read_size_i = 3'h0;
  logic fwd_no_snoop_o;
  logic [2:0] fwd_read_size_o;
  logic tag_req_i = 1'b0;
  logic [pdc_pkg::TAG_W-1:0] tag_o;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] rdata;
  logic rerr;

  pdc_dev_ctrl_status i_pdc_dev_ctrl_status (
    .clk_i(clk_i), .arst_n_i(arst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .err_i(err_i), .err_report_o(err_report_o),
    .max_payload_code_o(max_payload_code_o), .max_payload_bytes_o(max_payload_bytes_o),
    .max_payload_supported_o(max_payload_supported_o),
    .relaxed_ordering_attr_o(relaxed_ordering_attr_o), .no_snoop_attr_o(no_snoop_attr_o),
    .fwd_no_snoop_i(fwd_no_snoop_i), .fwd_read_size_i(fwd_read_size_i),
    .fwd_no_snoop_o(fwd_no_snoop_o), .fwd_read_size_o(fwd_read_size_o),
    .tag_req_i(tag_req_i), .tag_o(tag_o)
  );

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [pdc_pkg::ADDR_W-1:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rdata = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // read a mapped register and compare data and error response
  task automatic rdchk(input string name, input logic [pdc_pkg::ADDR_W-1:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rdata);
    chk("pslverr", 32'h0, {31'h0, rerr});
  endtask

  // one-cycle error pulse; report registered on the same edge that samples it, checked at the next negedge
  task automatic pulse_err(input logic [3:0] e, input logic [3:0] exp_rep);
    err_i <= e;
    @(posedge clk_i);
    err_i <= '0;
    @(negedge clk_i);
    chk("err_report", {28'h0, exp_rep}, {28'h0, err_report_o});
    @(posedge clk_i);
  endtask

  // hold the tag request for n edges, then compare the tag
  task automatic tag_run(input int n, input logic [7:0] exp);
    tag_req_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    tag_req_i <= 1'b0;
    @(negedge clk_i);
    chk("tag", {24'h0, exp}, {24'h0, tag_o});
    @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    // reset values and constant outputs
    rdchk("ctrl_rst", pdc_pkg::CTRL_ADDR, 32'h0);
    rdchk("sts_rst", pdc_pkg::STS_ADDR, 32'h0);
    chk("bytes_rst", 32'h80, {20'h0, max_payload_bytes_o});
    chk("supported", 32'h4, {29'h0, max_payload_supported_o});
    // all ones: only enables, payload field and extended tag stick
    apb(1'b1, pdc_pkg::CTRL_ADDR, 32'hffff_ffff);
    rdchk("ctrl_ones", pdc_pkg::CTRL_ADDR, 32'h01ef);
    chk("relaxed", 32'h0, {31'h0, relaxed_ordering_attr_o});
    chk("no_snoop", 32'h0, {31'h0, no_snoop_attr_o});
    // every payload code, reserved ones fall back to 128 bytes
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, pdc_pkg::CTRL_ADDR, 32'(c << 5));
      @(negedge clk_i);
      chk("mps_code", (c <= 4) ? c : 0, {29'h0, max_payload_code_o});
      chk("mps_bytes", (c <= 4) ? (128 << c) : 128, {20'h0, max_payload_bytes_o});
      @(posedge clk_i);
      rdchk("mps_field", pdc_pkg::CTRL_ADDR, 32'(c << 5));
    end
    // errors logged with reporting off, no report pulse
    apb(1'b1, pdc_pkg::CTRL_ADDR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      pulse_err(4'(1 << i), 4'h0);
      rdchk("sts_flag", pdc_pkg::STS_ADDR, 32'((2 << i) - 1));
    end
    // writing zeros keeps flags; writing ones clears only the chosen ones
    apb(1'b1, pdc_pkg::STS_ADDR, 32'h0000_fff0);
    rdchk("sts_keep", pdc_pkg::STS_ADDR, 32'h000f);
    apb(1'b1, pdc_pkg::STS_ADDR, 32'h0000_0005);
    rdchk("sts_part", pdc_pkg::STS_ADDR, 32'h000a);
    apb(1'b1, pdc_pkg::STS_ADDR, 32'h0000_ffff);
    rdchk("sts_clr", pdc_pkg::STS_ADDR, 32'h0);
    // error and write-one clear on the same edge: the error must win
    fork
      apb(1'b1, pdc_pkg::STS_ADDR, 32'h0000_0002);
      begin
        @(posedge clk_i);
        err_i <= 4'h2;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        err_i <= '0;
      end
    join
    rdchk("sts_set_wins", pdc_pkg::STS_ADDR, 32'h0002);
    // each enable gates its own class only
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, pdc_pkg::CTRL_ADDR, 32'(1 << i));
      pulse_err(4'hf, 4'(1 << i));
    end
    rdchk("sts_all", pdc_pkg::STS_ADDR, 32'h000f);
    // unmapped address: error response, zero data, write ignored
    apb(1'b1, 12'h124, 32'hffff);
    chk("slverr_wr", 32'h1, {31'h0, rerr});
    apb(1'b0, 12'h124, 32'h0);
    chk("slverr_rd", 32'h1, {31'h0, rerr});
    chk("unmapped_data", 32'h0, rdata);
    rdchk("ctrl_kept", pdc_pkg::CTRL_ADDR, 32'h0008);
    // forwarded attributes pass unchanged
    for (int i = 0; i < 8; i++) begin
      fwd_no_snoop_i <= ~i[0];
      fwd_read_size_i <= 3'(i);
      @(posedge clk_i);
      @(negedge clk_i);
      chk("fwd_ns", {31'h0, ~i[0]}, {31'h0, fwd_no_snoop_o});
      chk("fwd_size", 32'(i), {29'h0, fwd_read_size_o});
      @(posedge clk_i);
    end
    // debug tags: 0..31 without extended tag, 0..255 with it
    apb(1'b1, pdc_pkg::DBG_ADDR, 32'h1);
    rdchk("dbg", pdc_pkg::DBG_ADDR, 32'h0041);
    tag_run(33, 8'h01);
    apb(1'b1, pdc_pkg::CTRL_ADDR, 32'h0100);
    tag_run(200, 8'hc9);
    tag_run(55, 8'h00);
    tag_run(5, 8'h05);
    apb(1'b1, pdc_pkg::DBG_ADDR, 32'h0);
    tag_run(3, 8'h00);
    // second reset in mid-run restores defaults
    // payload code 4 first, so the byte count must really fall back to 128
    apb(1'b1, pdc_pkg::CTRL_ADDR, 32'h008f);
    arst_n_i <= 1'b0;
    @(posedge clk_i);
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    rdchk("ctrl_rst2", pdc_pkg::CTRL_ADDR, 32'h0);
    chk("bytes_rst2", 32'h80, {20'h0, max_payload_bytes_o});
    give_verdict();
  end

endmodule
